// ### gpt_defs.vh
// register offsets, field positions, reset values and timing counts for the pin port and timer
`ifndef GPT_DEFS_VH
`define GPT_DEFS_VH
`define GPT_OFF_DIR        8'h00
`define GPT_OFF_OUT        8'h04
`define GPT_OFF_IN         8'h08
`define GPT_OFF_SETCLR     8'h0C
`define GPT_OFF_TRIGEN     8'h10
`define GPT_OFF_IRQEN      8'h14
`define GPT_OFF_IRQEDGE    8'h18
`define GPT_OFF_IRQSTAT    8'h1C
`define GPT_OFF_TCTRL      8'h20
`define GPT_OFF_TTRIGSEL   8'h24
`define GPT_OFF_TCOUNT     8'h28
`define GPT_OFF_TRELOAD    8'h2C
`define GPT_SET_LSB        0
`define GPT_CLR_LSB        16
`define GPT_CTRL_EN        0
`define GPT_CTRL_TC        1
`define GPT_CTRL_SR        2
`define GPT_CTRL_LE        3
`define GPT_CTRL_PN        4
`define GPT_CTRL_OVF       5
`define GPT_RST_BYTE       8'h00
`define GPT_RST_WORD       32'h00000000
`define GPT_TERMINAL       32'hFFFFFFFF
`define GPT_SYNC_STAGES    2
`endif

// ### gpt_sync.v
// two-stage synchroniser for the eight pin inputs
`timescale 1ns/10ps
module gpt_sync (
  input  wire       clk_sys,
  input  wire       reset,
  input  wire [7:0] pin_async,
  output reg  [7:0] pin_sync
);
  reg [7:0] stage_one;

  always @(posedge clk_sys) begin
    if (reset) begin
      stage_one <= 8'h00;
      pin_sync  <= 8'h00;
    end else begin
      stage_one <= pin_async;
      pin_sync  <= stage_one;
    end
  end
endmodule // gpt_sync

// ### gpt_trig.v
// trigger qualifier: judges one selected pin as active per edge/level mode
`timescale 1ns/10ps
module gpt_trig (
  input  wire clk_sys,
  input  wire reset,
  input  wire trig_in,
  input  wire trigger_level_or_edge,
  input  wire trigger_polarity,
  output reg  trig_active
);
  reg trig_prev;

  always @(posedge clk_sys) begin
    if (reset) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_in;
    end
  end

  always @* begin
    case ({trigger_level_or_edge, trigger_polarity})
      2'b00:   trig_active = trig_prev & ~trig_in;
      2'b01:   trig_active = ~trig_prev & trig_in;
      2'b10:   trig_active = ~trig_in;
      2'b11:   trig_active = trig_in;
      default: trig_active = 1'b0;
    endcase
  end
endmodule // gpt_trig

// ### gpt_top.v
// eight-pin port with edge interrupts and the 32-bit event timer it feeds
`timescale 1ns/10ps
`include "gpt_defs.vh"
module gpt_top (
  input  wire        clk_sys,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [31:0] reg_rdata,
  input  wire [7:0]  pin_in,
  output wire [7:0]  pin_out,
  output wire [7:0]  pin_oe_n,
  output wire        pin_irq,
  output reg         timer_irq
);
  reg  [7:0]  pin_direction;
  reg  [7:0]  output_level;
  reg  [7:0]  pin_trigger_enable;
  reg  [7:0]  pin_interrupt_enable;
  reg  [7:0]  pin_interrupt_edge;
  reg  [7:0]  pin_interrupt_status;
  reg  [7:0]  pin_prev;
  reg  [4:0]  timer_control;
  reg  [2:0]  timer_trigger_select;
  reg  [31:0] timer_count;
  reg  [31:0] timer_reload;
  reg         timer_overflow;
  reg  [31:0] next_count;
  reg         next_overflow;
  reg         next_stop;
  reg  [7:0]  next_status;
  reg  [7:0]  next_output;
  wire [7:0]  pin_sync;
  wire [7:0]  pin_input_ok;
  wire [7:0]  trig_pins;
  wire [7:0]  irq_pins;
  wire [7:0]  edge_hit;
  wire        trig_in;
  wire        trig_active;
  wire        count_event;
  wire        wr_dir;
  wire        wr_out;
  wire        wr_setclr;
  wire        wr_ctrl;
  wire        rd_status;

  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  assign wr_dir    = reg_write & hit(reg_addr, `GPT_OFF_DIR);
  assign wr_out    = reg_write & hit(reg_addr, `GPT_OFF_OUT);
  assign wr_setclr = reg_write & hit(reg_addr, `GPT_OFF_SETCLR);
  assign wr_ctrl   = reg_write & hit(reg_addr, `GPT_OFF_TCTRL);
  assign rd_status = reg_read & hit(reg_addr, `GPT_OFF_IRQSTAT);

  gpt_sync u_sync (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .pin_async (pin_in),
    .pin_sync  (pin_sync)
  );

  // drive only when direction set; low enable drives
  assign pin_oe_n = ~pin_direction;
  assign pin_out  = output_level;

  // input-only qualification for trigger and interrupt
  assign pin_input_ok = ~pin_direction;
  assign trig_pins    = pin_sync & pin_input_ok & pin_trigger_enable;
  assign irq_pins     = pin_input_ok & pin_interrupt_enable;

  // select one pin, gated by its enable
  assign trig_in = trig_pins[timer_trigger_select];

  gpt_trig u_trig (
    .clk_sys               (clk_sys),
    .reset                 (reset),
    .trig_in               (trig_in),
    .trigger_level_or_edge (timer_control[`GPT_CTRL_LE]),
    .trigger_polarity      (timer_control[`GPT_CTRL_PN]),
    .trig_active           (trig_active)
  );

  // per-pin edge choice, rising when the edge bit is set
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_edge
      // only enabled input pins raise an edge
      assign edge_hit[i] = irq_pins[i] & (pin_interrupt_edge[i] ?
                           (~pin_prev[i] & pin_sync[i]) : (pin_prev[i] & ~pin_sync[i]));
    end
  endgenerate

  // status set beats the read clear
  always @* begin
    next_status = pin_interrupt_status;
    if (rd_status) begin
      next_status = 8'h00;
    end
    next_status = next_status | edge_hit;
  end

  assign pin_irq = |pin_interrupt_status;

  always @* begin
    next_output = output_level;
    if (wr_out) begin
      next_output = reg_wdata[7:0];
    end
    if (wr_setclr) begin
      next_output = (output_level | reg_wdata[`GPT_SET_LSB +: 8])
                    & ~reg_wdata[`GPT_CLR_LSB +: 8];
    end
  end

  // timer mode counts every clock; counter mode gated by trigger
  assign count_event = timer_control[`GPT_CTRL_TC] ? trig_active : 1'b1;

  always @* begin
    next_count    = timer_count;
    next_overflow = 1'b0;
    next_stop     = 1'b0;
    if (timer_control[`GPT_CTRL_EN] & count_event) begin
      if (timer_count == `GPT_TERMINAL) begin
        next_count    = timer_reload;
        next_overflow = 1'b1;
        next_stop     = timer_control[`GPT_CTRL_SR];
      end else begin
        next_count = timer_count + 32'h00000001;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      pin_direction        <= `GPT_RST_BYTE;
      output_level         <= `GPT_RST_BYTE;
      pin_trigger_enable   <= `GPT_RST_BYTE;
      pin_interrupt_enable <= `GPT_RST_BYTE;
      pin_interrupt_edge   <= `GPT_RST_BYTE;
      pin_interrupt_status <= `GPT_RST_BYTE;
      pin_prev             <= `GPT_RST_BYTE;
      timer_control        <= 5'h00;
      timer_trigger_select <= 3'h0;
      timer_count          <= `GPT_RST_WORD;
      timer_reload         <= `GPT_RST_WORD;
      timer_overflow       <= 1'b0;
      timer_irq            <= 1'b0;
    end else begin
      pin_prev             <= pin_sync;
      output_level         <= next_output;
      pin_interrupt_status <= next_status;
      timer_overflow       <= next_overflow;
      timer_irq            <= next_overflow;
      timer_count          <= next_count;
      if (wr_dir) begin
        pin_direction <= reg_wdata[7:0];
      end
      if (reg_write & hit(reg_addr, `GPT_OFF_TRIGEN)) begin
        pin_trigger_enable <= reg_wdata[7:0];
      end
      if (reg_write & hit(reg_addr, `GPT_OFF_IRQEN)) begin
        pin_interrupt_enable <= reg_wdata[7:0];
      end
      if (reg_write & hit(reg_addr, `GPT_OFF_IRQEDGE)) begin
        pin_interrupt_edge <= reg_wdata[7:0];
      end
      if (reg_write & hit(reg_addr, `GPT_OFF_TTRIGSEL)) begin
        timer_trigger_select <= reg_wdata[2:0];
      end
      if (reg_write & hit(reg_addr, `GPT_OFF_TRELOAD)) begin
        timer_reload <= reg_wdata;
      end
      // software write of the count wins over counting
      if (reg_write & hit(reg_addr, `GPT_OFF_TCOUNT)) begin
        timer_count <= reg_wdata;
      end
      // stop clears the enable bit; a write in that cycle still wins
      if (wr_ctrl) begin
        timer_control <= reg_wdata[4:0];
      end else if (next_stop) begin
        timer_control[`GPT_CTRL_EN] <= 1'b0;
      end
    end
  end

  // register read mux, data one cycle later
  always @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= `GPT_RST_WORD;
    end else if (reg_read) begin
      case (reg_addr)
        `GPT_OFF_DIR:      reg_rdata <= {24'h000000, pin_direction};
        `GPT_OFF_OUT:      reg_rdata <= {24'h000000, output_level};
        `GPT_OFF_IN:       reg_rdata <= {24'h000000, pin_sync};
        `GPT_OFF_TRIGEN:   reg_rdata <= {24'h000000, pin_trigger_enable};
        `GPT_OFF_IRQEN:    reg_rdata <= {24'h000000, pin_interrupt_enable};
        `GPT_OFF_IRQEDGE:  reg_rdata <= {24'h000000, pin_interrupt_edge};
        `GPT_OFF_IRQSTAT:  reg_rdata <= {24'h000000, pin_interrupt_status};
        `GPT_OFF_TCTRL:    reg_rdata <= {26'h0, timer_overflow, timer_control};
        `GPT_OFF_TTRIGSEL: reg_rdata <= {29'h0, timer_trigger_select};
        `GPT_OFF_TCOUNT:   reg_rdata <= timer_count;
        `GPT_OFF_TRELOAD:  reg_rdata <= timer_reload;
        default:           reg_rdata <= `GPT_RST_WORD;
      endcase
    end else begin
      reg_rdata <= `GPT_RST_WORD;
    end
  end
endmodule // gpt_top

// ### gpt_chk.sv
// concurrent checks on the port and timer top ports
`timescale 1ns/10ps
`include "gpt_defs.vh"
module gpt_chk (
  input wire        clk_sys,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_write,
  input wire        reg_read,
  input wire [31:0] reg_rdata,
  input wire [7:0]  pin_in,
  input wire [7:0]  pin_out,
  input wire [7:0]  pin_oe_n,
  input wire        pin_irq,
  input wire        timer_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire wr_dir = reg_write && reg_addr == `GPT_OFF_DIR;
  wire wr_out = reg_write && reg_addr == `GPT_OFF_OUT;
  wire wr_sc  = reg_write && reg_addr == `GPT_OFF_SETCLR;
  wire rd_out = reg_read && reg_addr == `GPT_OFF_OUT;
  wire rd_st  = reg_read && reg_addr == `GPT_OFF_IRQSTAT;
  dir_drive_a:
    assert property (wr_dir |=> pin_oe_n == ~$past(reg_wdata[7:0])) else $error("dir");
  out_level_a:
    assert property (wr_out |=> pin_out == $past(reg_wdata[7:0])) else $error("out");
  set_clear_a:
    assert property (wr_sc |=> pin_out == (($past(pin_out) | $past(reg_wdata[7:0]))
      & ~$past(reg_wdata[23:16]))) else $error("setclr");
  reset_state_a:
    assert property ($fell(reset) |-> pin_oe_n == 8'hFF && pin_out == 8'h00 && !pin_irq)
      else $error("reset state");
  read_back_a:
    assert property (rd_out |=> reg_rdata == {24'h000000, $past(pin_out)}) else $error("rdback");
  status_read_a:
    assert property (rd_st && pin_irq && !$past(rd_st) |=> reg_rdata[7:0] != 8'h00)
      else $error("status");
  idle_zero_a:
    assert property (!reg_read |=> reg_rdata == 32'h00000000) else $error("rdata idle");
  timer_pulse_a:
    assert property (timer_irq |=> !timer_irq) else $error("irq pulse");
endmodule // gpt_chk

// ### gpt_pins.sv
// board-side model of the eight pins with internal pull-downs
`timescale 1ns/10ps
module gpt_pins (
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe_n,
  input  wire [7:0] drv_val,
  input  wire [7:0] drv_en,
  output wire [7:0] pin_in
);
  // device drives where enable low
  // undriven pins fall to the pull-down level
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & drv_en & drv_val);
endmodule // gpt_pins

// ### gpt_tb_top.sv
// testbench: bus tasks and one task per scenario
`timescale 1ns/10ps
`include "gpt_defs.vh"
module gpt_tb_top;
  reg         clk_sys = 1'b0;
  reg         reset = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h00000000;
  reg         reg_write = 1'b0;
  reg         reg_read = 1'b0;
  reg  [7:0]  drv_val = 8'h00;
  reg  [7:0]  drv_en = 8'hFF;
  wire [31:0] reg_rdata;
  wire [7:0]  pin_in;
  wire [7:0]  pin_out;
  wire [7:0]  pin_oe_n;
  wire        pin_irq;
  wire        timer_irq;
  integer     fails = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  integer     t0;
  integer     t1;
  integer     i;
  gpt_top u_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_irq(pin_irq), .timer_irq(timer_irq));
  gpt_pins u_pins (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drv_val(drv_val),
    .drv_en(drv_en), .pin_in(pin_in));
  always #2.5 clk_sys = ~clk_sys;
  // whole run needs about 370 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk_sys);
      reg_write <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      @(negedge clk_sys);
      chk(reg_rdata, exp);
    end
  endtask
  task wait_ti;
    begin
      t0 = 0;
      @(negedge clk_sys);
      while (timer_irq !== 1'b1 && t0 < 200) begin
        @(negedge clk_sys);
        t0 = t0 + 1;
      end
      chk({31'h0, timer_irq}, 32'h1);
    end
  endtask
  task t_out;
    begin
      wr(`GPT_OFF_OUT, 32'h5A); // level before direction
      wr(`GPT_OFF_DIR, 32'h0F);
      @(negedge clk_sys);
      chk({24'h0, pin_oe_n}, 32'hF0);
      chk({24'h0, pin_out}, 32'h5A);
      drv_val <= 8'hA5;
      // bit 2 both set and cleared: clear wins
      wr(`GPT_OFF_SETCLR, 32'h001C0085);
      repeat (4) @(posedge clk_sys);
      rc(`GPT_OFF_OUT, 32'hC3);
      rc(`GPT_OFF_IN, 32'hA3);
      wr(`GPT_OFF_DIR, 32'h00);
      rc(8'h40, 32'h0);
      $display("test output done");
    end
  endtask
  task t_irq;
    begin
      drv_val <= 8'h02;
      wr(`GPT_OFF_TRIGEN, 32'h03);
      wr(`GPT_OFF_IRQEDGE, 32'h01);
      repeat (4) @(posedge clk_sys);
      wr(`GPT_OFF_IRQEN, 32'h03);
      wr(`GPT_OFF_TRIGEN, 32'h00);
      repeat (6) @(posedge clk_sys);
      rc(`GPT_OFF_IRQSTAT, 32'h0);
      drv_val <= 8'h07;
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({31'h0, pin_irq}, 32'h1);
      rc(`GPT_OFF_IRQSTAT, 32'h01);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({31'h0, pin_irq}, 32'h0);
      drv_val <= 8'h00;
      repeat (6) @(posedge clk_sys);
      rc(`GPT_OFF_IRQSTAT, 32'h02);
      rc(`GPT_OFF_IRQSTAT, 32'h0);
      wr(`GPT_OFF_IRQEN, 32'h00);
      $display("test pin interrupt done");
    end
  endtask
  task t_timer;
    begin
      wr(`GPT_OFF_TRELOAD, 32'hFFFFFFF0);
      wr(`GPT_OFF_TCOUNT, 32'hFFFFFFF0);
      wr(`GPT_OFF_TCTRL, 32'h19);
      wait_ti;
      // wait_ti reuses t0 as its own poll counter
      t1 = cyc;
      wait_ti;
      chk(cyc - t1, 32'd16);
      wr(`GPT_OFF_TCTRL, 32'h00);
      wr(`GPT_OFF_TRELOAD, 32'h1234);
      wr(`GPT_OFF_TCOUNT, 32'hFFFFFFFD);
      wr(`GPT_OFF_TCTRL, 32'h05);
      wait_ti;
      repeat (3) @(posedge clk_sys);
      rc(`GPT_OFF_TCOUNT, 32'h1234);
      rc(`GPT_OFF_TCTRL, 32'h04);
      $display("test timer done");
    end
  endtask
  // m is {level, polarity}; pin 0 idles inactive
  task t_count(input [1:0] m, input en, input [31:0] exp);
    begin
      drv_val[0] <= ~m[0];
      wr(`GPT_OFF_TRIGEN, {31'h0, en});
      wr(`GPT_OFF_TTRIGSEL, 32'h0);
      wr(`GPT_OFF_TCOUNT, 32'h0);
      repeat (4) @(posedge clk_sys);
      wr(`GPT_OFF_TCTRL, {27'h0, m[0], m[1], 3'b011});
      for (t0 = 0; t0 < 3; t0 = t0 + 1) begin
        @(posedge clk_sys);
        drv_val[0] <= m[0];
        repeat (4) @(posedge clk_sys);
        drv_val[0] <= ~m[0];
        repeat (3) @(posedge clk_sys);
      end
      repeat (6) @(posedge clk_sys);
      wr(`GPT_OFF_TCTRL, 32'h0);
      rc(`GPT_OFF_TCOUNT, exp);
      $display("test counter mode %0d done", m);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks=%0d mismatches=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    chk({24'h0, pin_oe_n}, 32'hFF);
    rc(`GPT_OFF_TCTRL, 32'h0);
    t_out;
    t_irq;
    t_timer;
    for (i = 0; i < 4; i = i + 1)
      t_count(i[1:0], 1'b1, i[1] ? 32'd12 : 32'd3);
    t_count(2'b01, 1'b0, 32'd0);
    report_and_stop;
  end
endmodule // gpt_tb_top
bind gpt_top gpt_chk u_chk (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pin_irq(pin_irq), .timer_irq(timer_irq));
